// File: rtl/hpa_defs.svh
// constants for the protected-area ceiling logic
`ifndef HPA_DEFS_SVH
`define HPA_DEFS_SVH
// ============================================================
// address space and fixed translation geometry
`define HPA_ADDR_W 28
`define HPA_NATIVE_MAX 28'h1312cff
`define HPA_HEADS 5'h10
`define HPA_SPT 6'h3f
`define HPA_SECT_PER_CYL 29'h00003f0
`define HPA_MAX_CYL 16'h3fff
`endif

// File: rtl/hpa_pkg.sv
// types shared by the protected-area ceiling logic
package hpa_pkg;
	// ============================================================
	// commands as decoded from the task file
	typedef enum logic [2:0] {
		cmd_other = 3'h0,
		cmd_read_native = 3'h1,
		cmd_set_max = 3'h2,
		cmd_read = 3'h3,
		cmd_write = 3'h4,
		cmd_identify = 3'h5
	} cmd_type;
	// command sequencer states, one-hot
	typedef enum logic [2:0] {
		st_restore = 3'h1,
		st_idle = 3'h2,
		st_resp = 3'h4
	} state_type;
endpackage : hpa_pkg

// File: rtl/hpa_geometry.sv
// converts the user ceiling into identify capacity figures
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.svh"
module hpa_geometry (
	input wire logic [`HPA_ADDR_W-1:0] ceil_i, // highest user address
	output logic [15:0] cyl_o, // whole cylinders below the ceiling
	output logic [31:0] chs_cap_o, // sectors reachable by chs
	output logic [31:0] lba_cap_o // sectors reachable by lba
);
	logic [28:0] count;
	logic [28:0] cyl_full;
	// ============================================================
	// truncating division gives the boundary just below the ceiling
	always_comb begin
		count = {1'b0, ceil_i} + 29'h0000001;
		cyl_full = count / `HPA_SECT_PER_CYL;
		if (cyl_full > {13'h0000, `HPA_MAX_CYL}) begin
			cyl_o = `HPA_MAX_CYL;
		end else begin
			cyl_o = cyl_full[15:0];
		end
		chs_cap_o = 32'({cyl_o, 10'h000}) - 32'({cyl_o, 4'h0});
		lba_cap_o = {3'h0, count};
	end
endmodule : hpa_geometry
`default_nettype wire

// File: rtl/hpa_ceiling.sv
// current and non-volatile ceiling storage
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.svh"
module hpa_ceiling (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // hardware reset, async, high
	input wire logic por_i, // power-on reset, async, high
	input wire logic restore_i, // copy stored setting to current
	input wire logic set_i, // accepted set-maximum
	input wire logic keep_i, // setting survives hardware resets
	input wire logic [`HPA_ADDR_W-1:0] addr_i, // requested ceiling
	output logic [`HPA_ADDR_W-1:0] cur_o, // active ceiling
	output logic [`HPA_ADDR_W-1:0] nv_o // stored ceiling
);
	logic [`HPA_ADDR_W-1:0] cur_r, cur_nxt, nv_r, nv_nxt;
	// ============================================================
	// a volatile set touches only the current value
	always_comb begin
		cur_nxt = cur_r;
		nv_nxt = nv_r;
		if (restore_i) begin
			cur_nxt = nv_r;
		end else if (set_i) begin
			cur_nxt = addr_i;
			if (keep_i) begin
				nv_nxt = addr_i;
			end
		end
	end
	// hardware reset leaves the stored value alone; only power-on reloads it with the native maximum
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_r <= `HPA_NATIVE_MAX;
		end else begin
			cur_r <= cur_nxt;
		end
	end
	always_ff @(posedge clk_i or posedge por_i) begin
		if (por_i) begin
			nv_r <= `HPA_NATIVE_MAX;
		end else begin
			nv_r <= nv_nxt;
		end
	end
	assign cur_o = cur_r;
	assign nv_o = nv_r;
endmodule : hpa_ceiling
`default_nettype wire

// File: rtl/hpa_limit.sv
// protected-area ceiling: command checks, ceiling control, identify figures
// Notes on behaviour
// [RQ1] both read-native and set-maximum commands implemented
// [RQ2] identify shows protected-area support
// [RQ3] read-native returns true native maximum always
// [RQ4] set-maximum below native lowers user ceiling
// [RQ5] host puts read-native right before set-maximum
// [RQ6] identify capacity reflects only reduced space
// [RQ7] access above ceiling ends with idnf, err
// [RQ8] sector count bit picks volatile or kept
// [RQ9] reset restores last kept ceiling
// [RQ10] set above native maximum is aborted
// [RQ11] second kept set after reset aborted
// [RQ12] host uses one translation for both
// [RQ13] word one reports cylinder boundary below ceiling
// [RQ14] orphan sectors refused under chs translation
// [RQ15] boot flow: read native, set, read, reset
// [RQ16] save flow: read native, volatile set, copy
// [RQ17] abort set-maximum unless read-native just preceded
// [RQ18] separate current and kept ceilings held
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.svh"
module hpa_limit (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // hardware reset, async, high
	input wire logic por_i, // power-on reset, async, high
	input wire logic cmd_valid_i, // command strobe, one cycle
	input wire hpa_pkg::cmd_type cmd_code_i, // decoded command
	input wire logic [`HPA_ADDR_W-1:0] cmd_addr_i, // linear address
	input wire logic cmd_keep_i, // sector count bit: keep across reset
	input wire logic cmd_chs_i, // command used chs translation
	output logic done_o, // completion pulse
	output logic err_o, // error status
	output logic abort_o, // command aborted
	output logic idnf_o, // id not found
	output logic [`HPA_ADDR_W-1:0] result_o, // returned address
	output logic hpa_supp_o, // identify support flag
	output logic [15:0] id_cyl_o, // identify cylinders
	output logic [31:0] id_chs_cap_o, // identify chs capacity
	output logic [31:0] id_lba_cap_o // identify lba capacity
);
	import hpa_pkg::*;

	state_type state_r, state_nxt;
	logic rnm_prev_r, rnm_prev_nxt;
	logic kept_used_r, kept_used_nxt;
	logic done_r, done_nxt, err_r, err_nxt, abort_r, abort_nxt, idnf_r, idnf_nxt;
	logic [`HPA_ADDR_W-1:0] result_r, result_nxt;
	logic supp_r;
	logic [15:0] cyl_r;
	logic [31:0] chs_cap_r, lba_cap_r;
	logic [`HPA_ADDR_W-1:0] cur_w, nv_w;
	logic [15:0] cyl_w;
	logic [31:0] chs_cap_w, lba_cap_w;
	logic restore_w, set_ok_w, take_w, above_w, orphan_w;

	// ============================================================
	// ceiling storage and identify geometry
	hpa_ceiling u_ceiling (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.por_i(por_i),
		.restore_i(restore_w),
		.set_i(set_ok_w),
		.keep_i(cmd_keep_i),
		.addr_i(cmd_addr_i),
		.cur_o(cur_w),
		.nv_o(nv_w)
	);

	hpa_geometry u_geometry (
		.ceil_i(cur_w),
		.cyl_o(cyl_w),
		.chs_cap_o(chs_cap_w),
		.lba_cap_o(lba_cap_w)
	);

	// ============================================================
	// command acceptance and checks
	assign take_w = cmd_valid_i && (state_r == st_idle);
	assign restore_w = (state_r == st_restore); // [RQ9]
	// the chs check uses the whole-cylinder capacity, so orphans fall outside
	assign above_w = cmd_addr_i > cur_w; // [RQ7]
	assign orphan_w = cmd_chs_i && ({4'h0, cmd_addr_i} >= chs_cap_w); // [RQ14]
	// a set is accepted only right after read-native, within native range,
	// and at most one kept set per reset
	assign set_ok_w = take_w && (cmd_code_i == cmd_set_max) && rnm_prev_r // [RQ17] [RQ5]
		&& (cmd_addr_i <= `HPA_NATIVE_MAX) // [RQ10] [RQ4]
		&& !(cmd_keep_i && kept_used_r); // [RQ11] [RQ8] [RQ18]

	// ============================================================
	// sequencer and status next values
	always_comb begin
		state_nxt = state_r;
		rnm_prev_nxt = rnm_prev_r;
		kept_used_nxt = kept_used_r;
		done_nxt = 1'b0;
		err_nxt = err_r;
		abort_nxt = abort_r;
		idnf_nxt = idnf_r;
		result_nxt = result_r;
		unique case (state_r)
			st_restore: begin
				state_nxt = st_idle;
			end
			st_idle: begin
				if (take_w) begin
					state_nxt = st_resp;
					done_nxt = 1'b1;
					err_nxt = 1'b0;
					abort_nxt = 1'b0;
					idnf_nxt = 1'b0;
					// any command other than read-native breaks the pairing
					rnm_prev_nxt = (cmd_code_i == cmd_read_native); // [RQ17]
					unique case (cmd_code_i)
						cmd_read_native: begin
							result_nxt = `HPA_NATIVE_MAX; // [RQ3] [RQ1]
						end
						cmd_set_max: begin
							if (set_ok_w) begin
								result_nxt = cmd_addr_i; // [RQ4] [RQ1]
								kept_used_nxt = kept_used_r | cmd_keep_i; // [RQ11]
							end else begin
								abort_nxt = 1'b1; // [RQ10] [RQ17]
								err_nxt = 1'b1;
							end
						end
						cmd_read, cmd_write: begin
							if (above_w || orphan_w) begin
								idnf_nxt = 1'b1; // [RQ7] [RQ14]
								err_nxt = 1'b1;
							end
						end
						cmd_identify, cmd_other: begin
						end
						default: begin
							abort_nxt = 1'b1;
							err_nxt = 1'b1;
						end
					endcase
				end
			end
			st_resp: begin
				state_nxt = st_idle;
			end
		endcase
	end

	// one flop bank; outputs leave straight from here
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= st_restore;
			rnm_prev_r <= 1'b0;
			kept_used_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			abort_r <= 1'b0;
			idnf_r <= 1'b0;
			result_r <= '0;
			supp_r <= 1'b0;
			cyl_r <= 16'h0000;
			chs_cap_r <= 32'h00000000;
			lba_cap_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			rnm_prev_r <= rnm_prev_nxt;
			kept_used_r <= kept_used_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			abort_r <= abort_nxt;
			idnf_r <= idnf_nxt;
			result_r <= result_nxt;
			supp_r <= 1'b1; // [RQ2]
			// figures lag the ceiling by one cycle
			cyl_r <= cyl_w; // [RQ13]
			chs_cap_r <= chs_cap_w; // [RQ6]
			lba_cap_r <= lba_cap_w; // [RQ6]
		end
	end

	assign done_o = done_r;
	assign err_o = err_r;
	assign abort_o = abort_r;
	assign idnf_o = idnf_r;
	assign result_o = result_r;
	assign hpa_supp_o = supp_r;
	assign id_cyl_o = cyl_r;
	assign id_chs_cap_o = chs_cap_r;
	assign id_lba_cap_o = lba_cap_r;

	// ============================================================
	// checks
	sequence s_rnm_taken;
		take_w && cmd_code_i == cmd_read_native;
	endsequence
	sequence s_set_taken;
		take_w && cmd_code_i == cmd_set_max;
	endsequence
	sequence s_done_clean;
		done_o && !err_o && !abort_o;
	endsequence

	property p_native_read;
		@(posedge clk_i) disable iff (rst_i)
		s_rnm_taken |=> s_done_clean and (result_o == `HPA_NATIVE_MAX);
	endproperty
	a_native_read: assert property (p_native_read) else $error("native read wrong"); // [RQ3]

	property p_pair_needed;
		@(posedge clk_i) disable iff (rst_i)
		s_set_taken and !rnm_prev_r |=> done_o && abort_o && err_o;
	endproperty
	a_pair_needed: assert property (p_pair_needed) else $error("unpaired set accepted"); // [RQ17]

	property p_over_native;
		@(posedge clk_i) disable iff (rst_i)
		s_set_taken and (cmd_addr_i > `HPA_NATIVE_MAX) |=> abort_o;
	endproperty
	a_over_native: assert property (p_over_native) else $error("set above native kept"); // [RQ10]

	property p_above_ceiling;
		@(posedge clk_i) disable iff (rst_i)
		take_w && (cmd_code_i == cmd_read || cmd_code_i == cmd_write) && above_w
			|=> done_o && idnf_o && err_o;
	endproperty
	a_above_ceiling: assert property (p_above_ceiling) else $error("access above ceiling"); // [RQ7]

	property p_capacity_follows;
		logic [`HPA_ADDR_W-1:0] a;
		@(posedge clk_i) disable iff (rst_i)
		(set_ok_w, a = cmd_addr_i) |=> s_done_clean ##1 (id_lba_cap_o == {4'h0, a} + 32'h1);
	endproperty
	a_capacity_follows: assert property (p_capacity_follows) else $error("capacity stale"); // [RQ6]

	property p_supported;
		@(posedge clk_i) disable iff (rst_i)
		state_r != st_restore |-> hpa_supp_o;
	endproperty
	a_supported: assert property (p_supported) else $error("support flag low"); // [RQ2]

	// judged on the first idle edge: the edge that releases reset still
	// shows the reset value of the current ceiling
	property p_restore;
		@(posedge clk_i) disable iff (rst_i)
		state_r == st_idle && $past(state_r) == st_restore |-> cur_w == $past(nv_w);
	endproperty
	a_restore: assert property (p_restore) else $error("reset did not restore"); // [RQ9]

	property p_second_kept;
		@(posedge clk_i) disable iff (rst_i)
		s_set_taken and cmd_keep_i && kept_used_r |=> abort_o && $stable(nv_w);
	endproperty
	a_second_kept: assert property (p_second_kept) else $error("second kept set taken"); // [RQ11]

	property p_volatile_only;
		@(posedge clk_i) disable iff (rst_i)
		set_ok_w && !cmd_keep_i |=> $stable(nv_w) && cur_w == $past(cmd_addr_i);
	endproperty
	a_volatile_only: assert property (p_volatile_only) else $error("volatile set stored"); // [RQ18]

	property p_cyl_below;
		@(posedge clk_i) disable iff (rst_i)
		state_r == st_idle |-> id_chs_cap_o <= id_lba_cap_o
			&& (id_cyl_o == `HPA_MAX_CYL
			|| id_lba_cap_o - id_chs_cap_o < {3'h0, `HPA_SECT_PER_CYL});
	endproperty
	a_cyl_below: assert property (p_cyl_below) else $error("cylinder above ceiling"); // [RQ13]

	property p_answer;
		@(posedge clk_i) disable iff (rst_i)
		take_w |=> done_o;
	endproperty
	a_answer: assert property (p_answer) else $error("command not answered"); // [RQ1]

	property p_done_pulse;
		@(posedge clk_i) disable iff (rst_i)
		done_o |=> !done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle"); // [RQ1]

	property p_set_result;
		@(posedge clk_i) disable iff (rst_i)
		set_ok_w |=> s_done_clean and (result_o == $past(cmd_addr_i));
	endproperty
	a_set_result: assert property (p_set_result) else $error("set result wrong"); // [RQ4]

	property p_kept_both;
		@(posedge clk_i) disable iff (rst_i)
		set_ok_w && cmd_keep_i |=> nv_w == $past(cmd_addr_i) && cur_w == $past(cmd_addr_i);
	endproperty
	a_kept_both: assert property (p_kept_both) else $error("kept set not stored"); // [RQ8]

	property p_orphan;
		@(posedge clk_i) disable iff (rst_i)
		take_w && (cmd_code_i == cmd_read || cmd_code_i == cmd_write) && orphan_w
			|=> done_o && idnf_o && err_o;
	endproperty
	a_orphan: assert property (p_orphan) else $error("orphan access allowed"); // [RQ14]

	property p_inside_clean;
		@(posedge clk_i) disable iff (rst_i)
		take_w && (cmd_code_i == cmd_read || cmd_code_i == cmd_write) && !above_w && !orphan_w
			|=> s_done_clean and !idnf_o;
	endproperty
	a_inside_clean: assert property (p_inside_clean) else $error("access refused"); // [RQ7]

	property p_pair_break;
		@(posedge clk_i) disable iff (rst_i)
		take_w && cmd_code_i != cmd_read_native |=> !rnm_prev_r;
	endproperty
	a_pair_break: assert property (p_pair_break) else $error("pairing survived"); // [RQ17]
endmodule : hpa_limit
`default_nettype wire

// File: testbench/hpa_host_model.sv
// host boot firmware model issuing task-file commands to the ceiling logic
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.svh"
module hpa_host_model (
	input wire logic clk_i, // device clock
	input wire logic done_i, // completion pulse from the device
	output logic cmd_valid_o, // command strobe
	output var hpa_pkg::cmd_type cmd_code_o, // decoded command
	output logic [`HPA_ADDR_W-1:0] cmd_addr_o, // linear address
	output logic cmd_keep_o, // sector count keep bit
	output logic cmd_chs_o // chs translation used
);
	import hpa_pkg::*;
	logic hung;
	// ============================================================
	// idle bus at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = cmd_other;
		cmd_addr_o = '0;
		cmd_keep_o = 1'b0;
		cmd_chs_o = 1'b0;
		hung = 1'b0;
	end
	// ============================================================
	// one command, then a bounded wait for completion
	task automatic send(input cmd_type c, input logic [`HPA_ADDR_W-1:0] a, input logic k,
		input logic h);
		int n;
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= c;
		cmd_addr_o <= a;
		cmd_keep_o <= k;
		cmd_chs_o <= h;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_addr_o <= ~a; // released address shows no stale value
		n = 0;
		#1;
		while (done_i !== 1'b1 && n < 5) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		hung = (done_i !== 1'b1);
	endtask : send
endmodule : hpa_host_model
`default_nettype wire

// File: testbench/host_protected_area_limit_test.sv
// self-checking bench for the protected-area ceiling logic
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.svh"
module host_protected_area_limit_test;
	import hpa_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic cmd_valid_i, cmd_keep_i, cmd_chs_i, done_o, err_o, abort_o, idnf_o, hpa_supp_o;
	cmd_type cmd_code_i;
	logic [`HPA_ADDR_W-1:0] cmd_addr_i, result_o, a;
	logic [15:0] id_cyl_o;
	logic [15:0] lfsr = 16'h31e2;
	logic [31:0] id_chs_cap_o, id_lba_cap_o;
	int num_errors = 0;
	int comparisons = 0;
	always #20 clk_i = ~clk_i;
	hpa_limit i_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .cmd_addr_i(cmd_addr_i), .cmd_keep_i(cmd_keep_i),
		.cmd_chs_i(cmd_chs_i), .done_o(done_o), .err_o(err_o), .abort_o(abort_o),
		.idnf_o(idnf_o), .result_o(result_o), .hpa_supp_o(hpa_supp_o), .id_cyl_o(id_cyl_o),
		.id_chs_cap_o(id_chs_cap_o), .id_lba_cap_o(id_lba_cap_o));
	hpa_host_model i_host (.clk_i(clk_i), .done_i(done_o), .cmd_valid_o(cmd_valid_i),
		.cmd_code_o(cmd_code_i), .cmd_addr_o(cmd_addr_i), .cmd_keep_o(cmd_keep_i),
		.cmd_chs_o(cmd_chs_i));
	// ============================================================
	// expectation helpers
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : step
	// whole cylinders below the ceiling, capped at the largest cylinder
	function automatic logic [15:0] exp_cyl(input logic [`HPA_ADDR_W-1:0] c);
		logic [31:0] k;
		k = ({4'h0, c} + 32'h1) / 32'h3f0;
		return (k > 32'h3fff) ? 16'h3fff : k[15:0];
	endfunction : exp_cyl
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// a command whose completion never comes ends the run
	task automatic cmd(input cmd_type c, input logic [`HPA_ADDR_W-1:0] x, input logic h,
		input logic [2:0] e);
		i_host.send(c, x, 1'b0, h);
		if (i_host.hung) begin
			num_errors++;
			complete_run();
		end
		check("status err abort idnf", {29'h0, err_o, abort_o, idnf_o}, {29'h0, e});
	endtask : cmd
	// read-native immediately followed by set-maximum
	task automatic pset(input logic [`HPA_ADDR_W-1:0] x, input logic k, input logic [2:0] e);
		cmd(cmd_read_native, '0, 1'b0, 3'h0);
		check("native", {4'h0, result_o}, {4'h0, `HPA_NATIVE_MAX});
		i_host.send(cmd_set_max, x, k, 1'b0);
		if (i_host.hung) begin
			num_errors++;
			complete_run();
		end
		check("set status", {29'h0, err_o, abort_o, idnf_o}, {29'h0, e});
		check("set result", {4'h0, result_o}, {4'h0, (e == 3'h0) ? x : `HPA_NATIVE_MAX});
	endtask : pset
	task automatic check_id(input logic [`HPA_ADDR_W-1:0] c);
		@(posedge clk_i);
		#1;
		check("lba cap", id_lba_cap_o, {4'h0, c} + 32'h1);
		check("cylinders", {16'h0, id_cyl_o}, {16'h0, exp_cyl(c)});
		check("chs cap", id_chs_cap_o, {16'h0, exp_cyl(c)} * 32'h3f0);
	endtask : check_id
	task automatic hw_reset(input logic p);
		@(posedge clk_i);
		rst_i <= 1'b1;
		por_i <= p;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : hw_reset
	// ============================================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		check("support", {31'h0, hpa_supp_o}, 32'h1);
		check_id(`HPA_NATIVE_MAX);
		// an identify between read-native and set-maximum breaks the pairing
		cmd(cmd_read_native, '0, 1'b0, 3'h0);
		cmd(cmd_identify, '0, 1'b0, 3'h0);
		cmd(cmd_set_max, 28'h0000100, 1'b0, 3'h6);
		pset(`HPA_NATIVE_MAX + 28'h1, 1'b0, 3'h6);
		cmd(cmd_type'(3'h6), '0, 1'b0, 3'h6);
		$display("test commands done");
		// random volatile ceilings, first one at the native maximum
		for (int i = 0; i < 6; i++) begin
			a = ({lfsr[11:0], step(lfsr)}) % `HPA_NATIVE_MAX;
			lfsr = step(step(lfsr));
			if (i == 0) begin
				a = `HPA_NATIVE_MAX;
			end
			pset(a, 1'b0, 3'h0);
			check_id(a);
			cmd(cmd_read, a, 1'b0, 3'h0);
			cmd(cmd_write, a + 28'h1, 1'b0, 3'h5);
		end
		$display("test ceilings done");
		// ceiling off a cylinder boundary leaves orphans past the chs capacity
		pset(28'h00003f3, 1'b0, 3'h0);
		check_id(28'h00003f3);
		cmd(cmd_read, 28'h00003f0, 1'b1, 3'h5);
		cmd(cmd_read, 28'h00003f0, 1'b0, 3'h0);
		$display("test orphans done");
		// kept against volatile ceilings across resets
		pset(28'h00abcde, 1'b1, 3'h0);
		pset(28'h0001234, 1'b0, 3'h0);
		check_id(28'h0001234);
		hw_reset(1'b0);
		check_id(28'h00abcde);
		pset(28'h0002000, 1'b1, 3'h0);
		pset(28'h0002000, 1'b1, 3'h6);
		// save flow: volatile set to native, write the reserved area, reset
		pset(`HPA_NATIVE_MAX, 1'b0, 3'h0);
		cmd(cmd_write, 28'h0003000, 1'b0, 3'h0);
		hw_reset(1'b0);
		check_id(28'h0002000);
		hw_reset(1'b1);
		check_id(`HPA_NATIVE_MAX);
		$display("test resets done");
		complete_run();
	end
endmodule : host_protected_area_limit_test
`default_nettype wire
